// *** hw/eia_align_check.sv ***
/*
 * combinational misalignment detector for one instruction presented for completion.
 * assumes kind, address and page attribute are stable and from the core clock domain.
 */
module eia_align_check
   import eia_pkg::*;
#(
   parameter bit HAS_FP = 1'b1
) (
   input  eia_pkg::eia_acc_e kind,
   input  wire logic [31:0]  ea,
   input  wire logic         le_mode,
   input  wire logic         page_wt_ci,
   output logic              fault
);

   function automatic logic word_misaligned(input logic [31:0] a);
      return a[1:0] != 2'h0;
   endfunction

   function automatic logic natural_misaligned(input eia_acc_e k, input logic [31:0] a);
      case (k)
         ACC_HALF:                   return a[0];
         ACC_WORD, ACC_FP_SINGLE,
         ACC_RESERVE_LOAD,
         ACC_COND_STORE:             return word_misaligned(a);
         ACC_DOUBLE, ACC_FP_DOUBLE:  return a[2:0] != 3'h0;
         default:                    return 1'b0;
      endcase
   endfunction

   always_comb begin
      fault = 1'b0;
      if ((kind == ACC_FP_SINGLE || kind == ACC_FP_DOUBLE) && HAS_FP && word_misaligned(ea))
         fault = 1'b1;
      if ((kind == ACC_MULTIPLE || kind == ACC_RESERVE_LOAD || kind == ACC_COND_STORE)
          && word_misaligned(ea))
         fault = 1'b1;
      if (le_mode && natural_misaligned(kind, ea))
         fault = 1'b1;
      if (le_mode && (kind == ACC_MULTIPLE || kind == ACC_STRING))
         fault = 1'b1;
      if (kind == ACC_CACHE_ZERO && page_wt_ci)
         fault = 1'b1;
   end

endmodule

// *** hw/eia_exc_unit.sv ***
/*
 * external interrupt and alignment exception entry, with an axi4-lite slave
 * for the state registers.
 * assumes the pipeline offers each completing instruction on valid/ready,
 * flags its own higher exceptions on other_exc and shows an empty store queue.
 */
// Operation
// - take request only while enable bit set
// - higher-priority exception same cycle wins
// - halt: next completes, rest blocked, stores drain
// - other exceptions first, interrupt postponed
// - saved status: upper cleared, lower copied
// - entry clears most state bits, endian copied
// - no-float variant holds fp bits zero
// - interrupt vector offset 0x500 from base
// - misaligned float access faults
// - misaligned multiple/reserve/conditional access faults
// - misaligned little-endian access faults
// - multiple/string in little-endian always faults
// - cache zero on wt/ci page faults
// - alignment saves faulting instruction address
// - alignment records cause register
// - alignment vector offset 0x600 from base
// - alignment saves effective address
// - register field copied into cause bits
module eia_exc_unit
   import eia_pkg::*;
#(
   parameter bit HAS_FP = 1'b1
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // control bus
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // external request pin
   input  wire logic               ext_irq_req_n,
   // pipeline side
   input  wire logic               other_exc,
   input  wire logic               insn_valid,
   output logic                    insn_ready,
   input  wire logic [31:0]        insn_pc,
   input  wire logic [31:0]        insn_next_pc,
   input  wire logic [31:0]        insn_word,
   input  wire logic [31:0]        insn_ea,
   input  eia_pkg::eia_acc_e       insn_kind,
   input  wire logic               insn_page_wt_ci,
   input  wire logic               store_queue_empty,
   output logic                    completion_block,
   output logic                    exc_take,
   output logic                    exc_is_align,
   output logic [31:0]             exc_vector,
   output logic [31:0]             machine_state_word
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   // state word as it stands after any exception entry
   function automatic logic [31:0] msw_on_entry(input logic [31:0] m);
      logic [31:0] n;
      n = '0;
      n[POS_MCHK_EN]       = m[POS_MCHK_EN];
      n[POS_VEC_BASE_SEL]  = m[POS_VEC_BASE_SEL];
      n[POS_EXC_ENDIAN]    = m[POS_EXC_ENDIAN];
      n[POS_LITTLE_ENDIAN] = m[POS_EXC_ENDIAN];
      return n;
   endfunction

   function automatic logic [31:0] vector_for(input logic sel, input logic [31:0] ofs);
      return (sel ? VEC_BASE_HIGH : VEC_BASE_LOW) | ofs;
   endfunction

   // software may not set bits the variant lacks
   function automatic logic [31:0] msw_legal(input logic [31:0] m);
      logic [31:0] n;
      n = m;
      if (!HAS_FP) begin
         n[POS_FP_AVAIL]  = 1'b0;
         n[POS_FP_MODE_A] = 1'b0;
         n[POS_FP_MODE_B] = 1'b0;
      end
      return n;
   endfunction

   function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   eia_state_e    state_q;
   logic          irq_level;
   logic          irq_seen;
   logic          irq_go;
   logic          align_fault;
   logic          accept;
   logic          take_align;
   logic          take_irq;
   logic [31:0]   next_pc_q;
   logic [31:0]   msw_q;
   logic [31:0]   saved_pc_q;
   logic [31:0]   saved_status_q;
   logic [31:0]   fault_cause_q;
   logic [31:0]   fault_addr_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic          aw_held_q;
   logic [31:0]   wdata_q;
   logic [3:0]    wstrb_q;
   logic          w_held_q;
   logic          wr_fire;
   logic          wr_hit;
   logic          rd_hit;
   logic [31:0]   rd_value;

   ////////////////////////////////////////////////////////////////////////////
   // request pin and detectors
   eia_sync2 #(
      .RESET_VAL (1'b1)
   ) u_irq_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (ext_irq_req_n),
      .sync_out (irq_level)
   );

   assign irq_seen = !irq_level;
   // a masked request is dropped, not remembered
   assign irq_go   = irq_seen && msw_q[POS_EXT_IRQ_EN] && !other_exc;

   eia_align_check #(
      .HAS_FP (HAS_FP)
   ) u_align (
      .kind       (insn_kind),
      .ea         (insn_ea),
      .le_mode    (msw_q[POS_LITTLE_ENDIAN]),
      .page_wt_ci (insn_page_wt_ci),
      .fault      (align_fault)
   );

   ////////////////////////////////////////////////////////////////////////////
   // completion handshake and halt sequence
   // during the drain nothing further may complete
   assign insn_ready       = (state_q != ST_DRAIN);
   assign completion_block = (state_q != ST_IDLE);
   assign accept           = insn_valid && insn_ready;
   // the pipeline's own exception outranks an alignment fault
   assign take_align       = accept && align_fault && !other_exc;
   assign take_irq         = (state_q == ST_DRAIN) && store_queue_empty;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (irq_go && !take_align) begin
                  state_q <= accept ? ST_DRAIN : ST_HALT;
               end
            end
            ST_HALT: begin
               if (!msw_q[POS_EXT_IRQ_EN]) begin
                  state_q <= ST_IDLE;
               end else if (accept) begin
                  // an excepting instruction postpones the interrupt
                  state_q <= (take_align || other_exc) ? ST_IDLE : ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (store_queue_empty) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // address of the instruction after the one allowed to complete
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         next_pc_q <= REG_RESET;
      end else if (accept && state_q != ST_DRAIN) begin
         next_pc_q <= insn_next_pc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // exception entry outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_take     <= 1'b0;
         exc_is_align <= 1'b0;
         exc_vector   <= REG_RESET;
      end else begin
         exc_take <= take_align || take_irq;
         if (take_align) begin
            exc_is_align <= 1'b1;
            exc_vector   <= vector_for(msw_q[POS_VEC_BASE_SEL], VEC_OFS_ALIGN);
         end else if (take_irq) begin
            exc_is_align <= 1'b0;
            exc_vector   <= vector_for(msw_q[POS_VEC_BASE_SEL], VEC_OFS_IRQ);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // architectural state registers; hardware entry wins over a software write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         msw_q <= MSW_RESET;
      end else if (take_align || take_irq) begin
         msw_q <= msw_on_entry(msw_q);
      end else if (wr_fire && awaddr_q == OFS_MSW) begin
         msw_q <= msw_legal(apply_strobe(msw_q, wdata_q, wstrb_q));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         saved_pc_q <= REG_RESET;
      end else if (take_align) begin
         saved_pc_q <= insn_pc;
      end else if (take_irq) begin
         saved_pc_q <= next_pc_q;
      end else if (wr_fire && awaddr_q == OFS_SAVED_PC) begin
         saved_pc_q <= apply_strobe(saved_pc_q, wdata_q, wstrb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         saved_status_q <= REG_RESET;
      end else if (take_align || take_irq) begin
         saved_status_q <= msw_q & SAVED_STATUS_MASK;
      end else if (wr_fire && awaddr_q == OFS_SAVED_STATUS) begin
         saved_status_q <= apply_strobe(saved_status_q, wdata_q, wstrb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_cause_q <= REG_RESET;
      end else if (take_align) begin
         fault_cause_q <= '0;
         fault_cause_q[CAUSE_REG_LSB +: REG_FIELD_W] <=
            insn_word[INSN_REG_LSB +: REG_FIELD_W];
      end else if (wr_fire && awaddr_q == OFS_FAULT_CAUSE) begin
         fault_cause_q <= apply_strobe(fault_cause_q, wdata_q, wstrb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_addr_q <= REG_RESET;
      end else if (take_align) begin
         fault_addr_q <= insn_ea;
      end else if (wr_fire && awaddr_q == OFS_FAULT_ADDR) begin
         fault_addr_q <= apply_strobe(fault_addr_q, wdata_q, wstrb_q);
      end
   end

   assign machine_state_word = msw_q;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write side: address and data held independently
   assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
   assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_hit        = awaddr_q[1:0] == 2'h0 && awaddr_q <= OFS_UNIT_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read side
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_hit        = s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= OFS_UNIT_STATUS;

   always_comb begin
      rd_value = '0;
      case (s_axi_araddr)
         OFS_MSW:          rd_value = msw_q;
         OFS_SAVED_PC:     rd_value = saved_pc_q;
         OFS_SAVED_STATUS: rd_value = saved_status_q;
         OFS_FAULT_CAUSE:  rd_value = fault_cause_q;
         OFS_FAULT_ADDR:   rd_value = fault_addr_q;
         OFS_UNIT_STATUS:  rd_value = {28'h0000000, state_q, irq_go, irq_seen};
         default:          rd_value = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_value;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// *** hw/eia_pkg.sv ***
/*
 * offsets, state-word fields, vectors, access kinds and states of the exception unit.
 * assumes a 32-bit core, bit 0 the lsb of every word.
 */
package eia_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the control bus
   localparam int unsigned ADDR_W           = 8;
   localparam logic [7:0]  OFS_MSW          = 8'h00;
   localparam logic [7:0]  OFS_SAVED_PC     = 8'h04;
   localparam logic [7:0]  OFS_SAVED_STATUS = 8'h08;
   localparam logic [7:0]  OFS_FAULT_CAUSE  = 8'h0C;
   localparam logic [7:0]  OFS_FAULT_ADDR   = 8'h10;
   localparam logic [7:0]  OFS_UNIT_STATUS  = 8'h14;

   localparam logic [31:0] MSW_RESET        = 32'h0000_0000;
   localparam logic [31:0] REG_RESET        = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // machine state word fields (lsb numbering)
   localparam int unsigned POS_POWER_SAVE    = 18;
   localparam int unsigned POS_ALT_GPR       = 17;
   localparam int unsigned POS_EXC_ENDIAN    = 16;
   localparam int unsigned POS_EXT_IRQ_EN    = 15;
   localparam int unsigned POS_PRIVILEGE     = 14;
   localparam int unsigned POS_FP_AVAIL      = 13;
   localparam int unsigned POS_MCHK_EN       = 12;
   localparam int unsigned POS_FP_MODE_A     = 11;
   localparam int unsigned POS_SINGLE_STEP   = 10;
   localparam int unsigned POS_BRANCH_TRACE  = 9;
   localparam int unsigned POS_FP_MODE_B     = 8;
   localparam int unsigned POS_VEC_BASE_SEL  = 6;
   localparam int unsigned POS_INSN_XLATE    = 5;
   localparam int unsigned POS_DATA_XLATE    = 4;
   localparam int unsigned POS_RECOVERABLE   = 1;
   localparam int unsigned POS_LITTLE_ENDIAN = 0;

   // saved status keeps only the low half of the word
   localparam logic [31:0] SAVED_STATUS_MASK = 32'h0000_FFFF;

   // cause register: register field of the faulting instruction
   localparam int unsigned CAUSE_REG_LSB = 5;
   localparam int unsigned INSN_REG_LSB  = 21;
   localparam int unsigned REG_FIELD_W   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // vectors
   localparam logic [31:0] VEC_BASE_LOW  = 32'h0000_0000;
   localparam logic [31:0] VEC_BASE_HIGH = 32'hFFF0_0000;
   localparam logic [31:0] VEC_OFS_IRQ   = 32'h0000_0500;
   localparam logic [31:0] VEC_OFS_ALIGN = 32'h0000_0600;

   ////////////////////////////////////////////////////////////////////////////
   // kinds of instruction presented for completion
   typedef enum logic [3:0] {
      ACC_NONE, ACC_BYTE, ACC_HALF, ACC_WORD, ACC_DOUBLE,
      ACC_FP_SINGLE, ACC_FP_DOUBLE, ACC_MULTIPLE, ACC_STRING,
      ACC_RESERVE_LOAD, ACC_COND_STORE, ACC_CACHE_ZERO
   } eia_acc_e;

   typedef enum logic [1:0] {
      ST_IDLE, ST_HALT, ST_DRAIN
   } eia_state_e;

endpackage

// *** hw/eia_sync2.sv ***
/*
 * two-flop level synchroniser for one asynchronous input.
 * assumes the input is a slow level; pulses shorter than one clock may vanish.
 */
module eia_sync2 #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// *** verification/eia_exc_chk_sva.sv ***
/*
 * concurrent checks on the pipeline side of the exception unit.
 * assumes it is bound into eia_exc_unit and shares its clock and reset.
 */
module eia_exc_chk #(
   parameter bit HAS_FP = 1'b1
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ext_irq_req_n,
   input wire logic        other_exc,
   input wire logic        insn_valid,
   input wire logic        insn_ready,
   input wire logic        store_queue_empty,
   input wire logic        completion_block,
   input wire logic        exc_take,
   input wire logic        exc_is_align,
   input wire logic [31:0] exc_vector,
   input wire logic [31:0] machine_state_word
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////
   sequence halt_start;
      $rose(completion_block);
   endsequence
   sequence halt_accept;
      completion_block && insn_valid && insn_ready && !other_exc && machine_state_word[15];
   endsequence
   sequence irq_entry;
      exc_take && !exc_is_align;
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   irq_enable_a: assert property (halt_start |-> $past(machine_state_word[15]))
      else $error("halt started with enable clear");
   irq_prio_a: assert property (halt_start |-> !$past(other_exc))
      else $error("halt started beside a higher exception");
   drain_block_a: assert property (halt_accept |=> !insn_ready || exc_take)
      else $error("later instruction not blocked");
   drain_save_a: assert property (irq_entry |-> $past(store_queue_empty)
      && $past(completion_block)) else $error("state saved before drain");
   // only machine check, vector select and exception endian survive entry
   entry_word_a: assert property (exc_take |->
      (machine_state_word & 32'hFFFE_EFBE) == 32'h0
      && machine_state_word[0] == machine_state_word[16]) else $error("bad entry word");
   fp_zero_a: assert property (!HAS_FP |-> machine_state_word[13] == 1'b0
      && machine_state_word[11] == 1'b0 && machine_state_word[8] == 1'b0)
      else $error("fp bits set without fp");
   irq_vec_a: assert property (irq_entry |-> exc_vector ==
      {machine_state_word[6] ? 12'hFFF : 12'h000, 20'h00500}) else $error("bad irq vector");
   align_vec_a: assert property (exc_take && exc_is_align |-> exc_vector ==
      {machine_state_word[6] ? 12'hFFF : 12'h000, 20'h00600}) else $error("bad align vector");
   pin_level_a: assert property (halt_start |-> !$past(ext_irq_req_n, 3))
      else $error("halt without synchronised request");
endmodule

// *** verification/eia_exc_unit_test.sv ***
/*
 * self-checking bench for the exception unit: bus access, interrupt, alignment.
 * assumes the checker and the request source model are compiled beforehand.
 */
module eia_exc_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import eia_pkg::*;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, other_exc = 0, insn_valid = 0;
   logic        insn_page_wt_ci = 0, store_queue_empty = 1, irq_raise = 0, irq_ack = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, insn_pc = 0, insn_next_pc = 0, insn_ea = 0;
   logic [31:0] insn_word = 32'h0260_0000;
   eia_acc_e    insn_kind = ACC_NONE;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        insn_ready, completion_block, exc_take, exc_is_align, ext_irq_req_n;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, exc_vector, machine_state_word;
   int          err_total = 0, cmp_count = 0, i;
   logic        s;
   eia_acc_e    k_t [9] = '{ACC_FP_SINGLE, ACC_MULTIPLE, ACC_RESERVE_LOAD, ACC_COND_STORE,
                            ACC_WORD, ACC_BYTE, ACC_STRING, ACC_CACHE_ZERO, ACC_CACHE_ZERO};
   logic [31:0] ea_t [9] = '{32'h102, 32'h101, 32'h102, 32'h100, 32'h102, 32'h103, 32'h100,
                             32'h100, 32'h100};
   logic [8:0]  le_t = 9'b0_0111_0000, wc_t = 9'b0_1000_0000, flt_t = 9'b0_1101_0111;

   eia_exc_unit #(.HAS_FP(1'b1)) eia_exc_unit_inst (.*);
   eia_irq_src eia_irq_src_inst (.aclk, .aresetn, .raise(irq_raise), .ack(irq_ack),
      .irq_req_n(ext_irq_req_n));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) break;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", r, er);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                       input string nm);
      logic ta, tr;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) break;
      end
      s_axi_rready <= 1'b0;
      chk(nm, d, exp);
      chk("rresp", r, er);
   endtask
   task automatic issue(input eia_acc_e k, input logic [31:0] pc, input logic [31:0] ea,
                        input logic wc);
      logic t;
      @(posedge aclk);
      insn_valid <= 1'b1;
      insn_kind <= k;
      insn_pc <= pc;
      insn_next_pc <= pc + 32'h4;
      insn_ea <= ea;
      insn_page_wt_ci <= wc;
      forever begin
         @(negedge aclk);
         t = insn_ready;
         @(posedge aclk);
         if (t) break;
      end
      insn_valid <= 1'b0;
   endtask
   task automatic wait_take(output logic seen);
      seen = 1'b0;
      repeat (4) begin
         @(negedge aclk);
         if (exc_take === 1'b1) seen = 1'b1;
      end
   endtask
   task automatic src(input logic r);
      @(posedge aclk);
      irq_raise <= r;
      irq_ack <= !r;
      @(posedge aclk);
      irq_raise <= 1'b0;
      irq_ack <= 1'b0;
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 aclk = ~aclk;
   end
   initial begin
      repeat (6000) @(posedge aclk);
      err_total++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0, RESP_OKAY, "reset value");
      rchk(8'h18, 32'h0, RESP_SLVERR, "unmapped read");
      wr(8'h18, 32'h1234_5678, RESP_SLVERR);
      $display("test bus done");
      store_queue_empty <= 1'b0;
      wr(OFS_MSW, 32'h0, RESP_OKAY);
      src(1'b1);
      repeat (8) @(negedge aclk);
      chk("halt while disabled", completion_block, 32'h0);
      @(posedge aclk) other_exc <= 1'b1;
      wr(OFS_MSW, 32'h0007_FF73, RESP_OKAY);
      repeat (6) @(negedge aclk);
      chk("halt beside other exception", completion_block, 32'h0);
      @(posedge aclk);
      other_exc <= 1'b0;
      repeat (5) @(negedge aclk);
      chk("halt on held level", completion_block, 32'h1);
      // halting instruction faults: alignment goes first, interrupt waits
      issue(ACC_RESERVE_LOAD, 32'h3000, 32'h102, 1'b0);
      wait_take(s);
      chk("postponed entry kind", {s, exc_is_align}, 32'h3);
      chk("align vector high", exc_vector, 32'hFFF0_0600);
      wr(OFS_MSW, 32'h0007_FF73, RESP_OKAY);
      repeat (5) @(negedge aclk);
      issue(ACC_WORD, 32'h3010, 32'h100, 1'b0);
      repeat (3) @(negedge aclk);
      chk("blocked in drain", {insn_ready, exc_take}, 32'h0);
      @(posedge aclk);
      store_queue_empty <= 1'b1;
      wait_take(s);
      chk("irq entry", {s, exc_is_align}, 32'h2);
      chk("irq vector", exc_vector, 32'hFFF0_0500);
      chk("entry word", machine_state_word, 32'h0001_1041);
      rchk(OFS_SAVED_PC, 32'h3014, RESP_OKAY, "irq saved pc");
      rchk(OFS_SAVED_STATUS, 32'h0000_FF73, RESP_OKAY, "saved status");
      src(1'b0);
      $display("test interrupt done");
      for (i = 0; i < 9; i++) begin
         wr(OFS_MSW, {31'h0, le_t[i]}, RESP_OKAY);
         issue(k_t[i], 32'h2000 + 32'(16 * i), ea_t[i], wc_t[i]);
         wait_take(s);
         chk("align fault", s, flt_t[i]);
         if (flt_t[i]) begin
            chk("align vector", exc_vector, 32'h0000_0600);
            chk("word after entry", machine_state_word, 32'h0);
            rchk(OFS_SAVED_PC, 32'h2000 + 32'(16 * i), RESP_OKAY, "saved pc");
            rchk(OFS_FAULT_ADDR, ea_t[i], RESP_OKAY, "fault address");
            rchk(OFS_FAULT_CAUSE, 32'h0000_0260, RESP_OKAY, "fault cause");
         end
      end
      $display("test alignment done");
      close_out();
   end
endmodule

bind eia_exc_unit eia_exc_chk #(.HAS_FP(HAS_FP)) eia_exc_chk_inst (.*);

// *** verification/eia_irq_src.sv ***
/*
 * model of the peripheral that drives the active-low interrupt request.
 * assumes raise and ack are one-cycle commands from the bench.
 */
module eia_irq_src (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic raise,
   input wire logic ack,
   output logic     irq_req_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // request stays low until the handler acknowledges; idle level is high
   always_ff @(posedge aclk) begin
      if (!aresetn) irq_req_n <= 1'b1;
      else if (ack) irq_req_n <= 1'b1;
      else if (raise) irq_req_n <= 1'b0;
   end
endmodule
